// ### hw/isb_pkg.sv
package isb_pkg;
  // register offsets, cpu special-function bus
  localparam logic [7:0] OFS_ADDR = 8'hE3;
  localparam logic [7:0] OFS_DATA = 8'hE4;
  localparam logic [7:0] OFS_CON  = 8'hE5;
  localparam logic [7:0] OFS_STAT = 8'hE8;
  localparam logic [7:0] OFS_PRE  = 8'hE9;
  // register offsets, secondary bus
  localparam logic [7:0] OFS_PORT = 8'h34;
  localparam logic [7:0] OFS_FILT = 8'h50;
  // reset values
  localparam logic [7:0] PORT_RESET = 8'h10;
  localparam logic [1:0] FILT_RESET = 2'h2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // field positions
  localparam int PORT_SEL_BIT  = 4;
  localparam int FILT_ANA_BIT  = 1;
  localparam int FILT_DIG_BIT  = 0;
  localparam int STAT_WCOL_BIT = 1;
  localparam int STAT_OVF_BIT  = 0;
  // byte timing in bus clocks and preload delay in system clocks
  localparam logic [3:0] CNT_BYTE   = 4'h8;
  localparam logic [3:0] CNT_LAST   = 4'h7;
  localparam logic [1:0] PRE_DELAY  = 2'h2;
  localparam int         FILT_TAPS  = 3;

  typedef struct packed {
    logic soft_rst;
    logic rd_stretch;
    logic wr_stretch;
    logic clock_release;
    logic slew_limit_off;
    logic module_on_bit;
  } isb_con_s;

  localparam isb_con_s CON_RESET = 6'h10;

  typedef struct packed {
    logic scl;
    logic sda;
  } isb_line_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX      = 3'b011,
    ST_RX_ACK  = 3'b100,
    ST_TX      = 3'b101,
    ST_TX_ACK  = 3'b110
  } isb_state_e;
endpackage

// ### hw/isb_filt.sv
`timescale 1ns/1ps
module isb_filt import isb_pkg::*; (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic raw_in,
  input  wire logic dig_on_in,
  output logic      level_out
);
  logic                 meta_q, sync_q, level_q, level_d;
  logic [FILT_TAPS-1:0] hist_q, hist_d;

  // glitch filter: a level passes only after it holds for all taps
  always_comb begin
    hist_d  = {hist_q[FILT_TAPS-2:0], sync_q};
    level_d = sync_q;
    if (dig_on_in) begin
      level_d = level_q;
      if (&hist_q) begin
        level_d = 1'b1;
      end else if (~|hist_q) begin
        level_d = 1'b0;
      end
    end
  end

  // two-stage synchroniser, meta_q feeds only sync_q
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_q  <= 1'b1;
      sync_q  <= 1'b1;
      hist_q  <= '1;
      level_q <= 1'b1;
    end else begin
      meta_q  <= raw_in;
      sync_q  <= meta_q;
      hist_q  <= hist_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule

// ### hw/isb_top.sv
`timescale 1ns/1ps
// Overview of operation
// - serial engine runs only while module_on_bit is 1
// - slew_limit_off 1 turns output slew control off for 100Kbps
// - clock_release 0 holds clock line low, 1 releases it
// - nothing drives the bus unless module_on_bit is set
// - write stretch on: clock forced low when receive interrupt fires
// - write stretch off: no clock pull at receive interrupt
// - read stretch on: hardware clears clock_release after address or sent byte
// - read stretch off: preload goes to shifter and out, no stretch
// - preload copied into shifter two clocks after interrupt
// - transmit msb first, eight master clocks per byte
// - receive stores byte after 8 clocks, interrupt after 9th
// - read stretch on: data writes only when direction 1, release 0
// - refused data write keeps register, sets write_collision_flag
// - soft reset bit resets all module flops but the secondary bus registers, itself global reset only
// - port bit 4 selects pin set A when 1, B when 0, reset 1
// - filter bit 1 enables analog filter, resets to 1
// - filter bit 0 enables digital filter, resets to 0
// - direction flag updated on falling edge of eighth clock
module isb_top import isb_pkg::*; (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       sfr_we_in,
  input  wire logic       sfr_re_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic       sec_we_in,
  input  wire logic       sec_re_in,
  input  wire logic [7:0] sec_addr_in,
  input  wire logic [7:0] sec_wdata_in,
  output logic      [7:0] sec_rdata_out,
  input  wire logic       scl_a_in,
  output logic            scl_a_out,
  output logic            scl_a_oe_n_out,
  input  wire logic       sda_a_in,
  output logic            sda_a_out,
  output logic            sda_a_oe_n_out,
  input  wire logic       scl_b_in,
  output logic            scl_b_out,
  output logic            scl_b_oe_n_out,
  input  wire logic       sda_b_in,
  output logic            sda_b_out,
  output logic            sda_b_oe_n_out,
  output logic            byte_irq_out,
  output logic            slew_limit_off_out,
  output logic            analog_filter_on_out
);
  isb_state_e st_q, st_d;
  isb_con_s   con_q, con_d;
  isb_line_s  raw, flt, prev_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, data_q, data_d, pre_q, pre_d, rd_q, rd_d;
  logic [7:0] port_q, port_d, srd_q, srd_d;
  logic [6:0] addr_q, addr_d;
  logic [1:0] pcnt_q, pcnt_d, filt_q, filt_d;
  logic       dir_q, dir_d, ad_q, ad_d, bf_q, bf_d, ack_q, ack_d, wcol_q, wcol_d;
  logic       ovf_q, ovf_d, start_q, start_d, stop_q, stop_d, irq_q, irq_d;
  logic       scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d;
  logic       mrst, pin_a, on, rise, fall, start_ev, stop_ev, data_ok;
  logic       wcol_set, ovf_set, hold_clr, tx_enter, own_busy;
  logic [7:0] own_q, own_d;

  // soft reset reaches every module flop except its own bit and the secondary bus registers
  assign mrst  = rst_in | con_q.soft_rst;
  assign pin_a = port_q[PORT_SEL_BIT];
  assign on    = con_q.module_on_bit;
  assign raw.scl = pin_a ? scl_a_in : scl_b_in;
  assign raw.sda = pin_a ? sda_a_in : sda_b_in;

  isb_filt u_scl_filt (
    .clock_in  (clock_in),
    .rst_in    (mrst),
    .raw_in    (raw.scl),
    .dig_on_in (filt_q[FILT_DIG_BIT]),
    .level_out (flt.scl)
  );
  isb_filt u_sda_filt (
    .clock_in  (clock_in),
    .rst_in    (mrst),
    .raw_in    (raw.sda),
    .dig_on_in (filt_q[FILT_DIG_BIT]),
    .level_out (flt.sda)
  );

  // bus events seen only after synchronising and filtering
  assign rise     = flt.scl & ~prev_q.scl;
  assign fall     = ~flt.scl & prev_q.scl;
  // our own data drive reaches the filter late, inside the high phase;
  // edges while we drive or just released are ours, not start or stop
  assign own_busy = sda_drv_q | (|own_q);
  assign start_ev = flt.scl & prev_q.scl & prev_q.sda & ~flt.sda & ~own_busy;
  assign stop_ev  = flt.scl & prev_q.scl & ~prev_q.sda & flt.sda & ~own_busy;
  // with read stretching the data register is only open while stretched
  assign data_ok  = ~con_q.rd_stretch | (dir_q & ~con_q.clock_release);

  // protocol engine and cpu register file
  always_comb begin
    st_d = st_q; con_d = con_q; cnt_d = cnt_q; sh_d = sh_q; tx_d = tx_q;
    data_d = data_q; pre_d = pre_q; addr_d = addr_q; pcnt_d = pcnt_q;
    dir_d = dir_q; ad_d = ad_q; bf_d = bf_q; ack_d = ack_q; wcol_d = wcol_q;
    ovf_d = ovf_q; start_d = start_q; stop_d = stop_q; irq_d = 1'b0;
    wcol_set = 1'b0; ovf_set = 1'b0; hold_clr = 1'b0; tx_enter = 1'b0;
    rd_d = rd_q;
    own_d = {own_q[6:0], sda_drv_q};
    if (sfr_we_in) begin
      unique case (sfr_addr_in)
        OFS_ADDR: addr_d = sfr_wdata_in[7:1];
        OFS_CON:  con_d  = sfr_wdata_in[5:0];
        OFS_PRE:  pre_d  = sfr_wdata_in;
        OFS_STAT: begin
          wcol_d = wcol_q & sfr_wdata_in[STAT_WCOL_BIT];
          ovf_d  = ovf_q & sfr_wdata_in[STAT_OVF_BIT];
        end
        OFS_DATA: begin
          if (data_ok) begin
            data_d = sfr_wdata_in;
            bf_d   = 1'b1;
          end else begin
            wcol_set = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (sfr_re_in) begin
      unique case (sfr_addr_in)
        OFS_ADDR: rd_d = {addr_q, 1'b0};
        OFS_DATA: rd_d = data_q;
        OFS_CON:  rd_d = {2'h0, con_q};
        OFS_STAT: rd_d = {start_q, stop_q, dir_q, ad_q, bf_q, ack_q, wcol_q, ovf_q};
        OFS_PRE:  rd_d = pre_q;
        default:  rd_d = 8'h00;
      endcase
      if (sfr_addr_in == OFS_DATA) begin
        bf_d = 1'b0;
      end
    end
    // preload handed to the shifter late, so software gets two clocks
    if (pcnt_q != 2'h0) begin
      pcnt_d = pcnt_q - 2'h1;
      if (pcnt_q == 2'h1) begin
        tx_d = pre_q;
      end
    end
    if (!on) begin
      st_d = ST_IDLE;
      cnt_d = 4'h0;
    end else if (start_ev) begin
      st_d = ST_ADDR; cnt_d = 4'h0; start_d = 1'b1; stop_d = 1'b0;
      ack_d = 1'b0; dir_d = 1'b0;
    end else if (stop_ev) begin
      st_d = ST_IDLE; stop_d = 1'b1; start_d = 1'b0; dir_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR, ST_RX: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], flt.sda};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == CNT_BYTE) begin
            cnt_d = 4'h0;
            if (st_q == ST_RX) begin
              ad_d = 1'b1;
              st_d = ST_RX_ACK;
              if (bf_q) begin
                ovf_set = 1'b1;
              end else begin
                data_d = sh_q;
                bf_d   = 1'b1;
              end
            end else if (sh_q[7:1] == addr_q) begin
              dir_d = sh_q[0];
              ad_d  = 1'b0;
              st_d  = ST_ADDR_ACK;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (fall) begin
            irq_d = 1'b1;
            if (st_q == ST_ADDR_ACK && dir_q) begin
              tx_enter = 1'b1;
            end else begin
              st_d = ST_RX;
              hold_clr = con_q.wr_stretch;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            tx_d  = {tx_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == CNT_LAST) begin
              st_d = ST_TX_ACK; cnt_d = 4'h0; bf_d = 1'b0; ad_d = 1'b1;
            end
          end
        end
        ST_TX_ACK: begin
          if (rise) begin
            ack_d = flt.sda;
          end
          if (fall) begin
            if (ack_q) begin
              st_d = ST_IDLE;
              dir_d = 1'b0;
            end else begin
              irq_d = 1'b1;
              tx_enter = 1'b1;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    if (tx_enter) begin
      st_d = ST_TX;
      cnt_d = 4'h0;
      if (con_q.rd_stretch) begin
        hold_clr = 1'b1;
      end else begin
        pcnt_d = PRE_DELAY;
      end
    end
    // software release during read stretch loads the shifter first
    if (sfr_we_in && sfr_addr_in == OFS_CON && con_d.clock_release && !con_q.clock_release
        && st_q == ST_TX && cnt_q == 4'h0 && con_q.rd_stretch) begin
      tx_d = data_q;
    end
    if (hold_clr) begin
      con_d.clock_release = 1'b0; // hardware clear beats software set
    end
    wcol_d = wcol_d | wcol_set; // set wins over clear
    ovf_d  = ovf_d | ovf_set;
    scl_drv_d = con_d.module_on_bit & ~con_d.clock_release;
    sda_drv_d = con_d.module_on_bit & (st_d == ST_ADDR_ACK || st_d == ST_RX_ACK
                || (st_d == ST_TX && !tx_d[7]));
  end

  always_ff @(posedge clock_in) begin
    if (mrst) begin
      st_q <= ST_IDLE; con_q <= CON_RESET; cnt_q <= 4'h0; sh_q <= 8'h00;
      con_q.soft_rst <= rst_in ? 1'b0 : con_d.soft_rst;
      tx_q <= 8'hFF; data_q <= DATA_RESET; pre_q <= DATA_RESET; addr_q <= 7'h00;
      pcnt_q <= 2'h0; dir_q <= 1'b0; ad_q <= 1'b0; bf_q <= 1'b0; ack_q <= 1'b1;
      wcol_q <= 1'b0; ovf_q <= 1'b0; start_q <= 1'b0; stop_q <= 1'b1;
      irq_q <= 1'b0; scl_drv_q <= 1'b0; sda_drv_q <= 1'b0; rd_q <= 8'h00;
      prev_q <= 2'b11; own_q <= 8'h00;
    end else begin
      st_q <= st_d; con_q <= con_d; cnt_q <= cnt_d; sh_q <= sh_d;
      tx_q <= tx_d; data_q <= data_d; pre_q <= pre_d; addr_q <= addr_d;
      pcnt_q <= pcnt_d; dir_q <= dir_d; ad_q <= ad_d; bf_q <= bf_d; ack_q <= ack_d;
      wcol_q <= wcol_d; ovf_q <= ovf_d; start_q <= start_d; stop_q <= stop_d;
      irq_q <= irq_d; scl_drv_q <= scl_drv_d; sda_drv_q <= sda_drv_d; rd_q <= rd_d;
      prev_q <= flt; own_q <= own_d;
    end
  end

  // secondary bus registers, global reset only
  always_comb begin
    port_d = port_q;
    filt_d = filt_q;
    srd_d  = srd_q;
    if (sec_we_in && sec_addr_in == OFS_PORT) begin
      port_d = sec_wdata_in;
    end
    if (sec_we_in && sec_addr_in == OFS_FILT) begin
      filt_d = sec_wdata_in[1:0];
    end
    if (sec_re_in) begin
      srd_d = (sec_addr_in == OFS_PORT) ? port_q :
              (sec_addr_in == OFS_FILT) ? {6'h00, filt_q} : 8'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port_q <= PORT_RESET;
      filt_q <= FILT_RESET;
      srd_q  <= 8'h00;
    end else begin
      port_q <= port_d;
      filt_q <= filt_d;
      srd_q  <= srd_d;
    end
  end

  // open drain: only the selected pin set ever pulls low
  assign scl_a_out      = 1'b0;
  assign sda_a_out      = 1'b0;
  assign scl_b_out      = 1'b0;
  assign sda_b_out      = 1'b0;
  assign scl_a_oe_n_out = ~(scl_drv_q & pin_a);
  assign sda_a_oe_n_out = ~(sda_drv_q & pin_a);
  assign scl_b_oe_n_out = ~(scl_drv_q & ~pin_a);
  assign sda_b_oe_n_out = ~(sda_drv_q & ~pin_a);
  assign sfr_rdata_out  = rd_q;
  assign sec_rdata_out  = srd_q;
  assign byte_irq_out   = irq_q;
  assign slew_limit_off_out   = con_q.slew_limit_off;
  assign analog_filter_on_out = filt_q[FILT_ANA_BIT];

  // checks
  off_quiet_a: assert property (@(posedge clock_in) disable iff (mrst)
    !on |-> !scl_drv_q && !sda_drv_q) else $error("bus driven while off");
  idle_off_a: assert property (@(posedge clock_in) disable iff (mrst)
    !on |=> st_q == ST_IDLE) else $error("engine active while off");
  clock_hold_a: assert property (@(posedge clock_in) disable iff (mrst)
    scl_drv_q == (on && !con_q.clock_release)) else $error("clock hold mismatch");
  rx_stretch_a: assert property (@(posedge clock_in) disable iff (mrst)
    irq_q && !dir_q && con_q.wr_stretch |-> !con_q.clock_release && scl_drv_q)
    else $error("no stretch on receive");
  rx_free_a: assert property (@(posedge clock_in) disable iff (mrst)
    irq_q && !dir_q && !con_q.wr_stretch && $past(con_q.clock_release)
    && !$past(sfr_we_in) |-> con_q.clock_release) else $error("needless stretch");
  tx_stretch_a: assert property (@(posedge clock_in) disable iff (mrst)
    irq_q && st_q == ST_TX && con_q.rd_stretch |-> !con_q.clock_release)
    else $error("no stretch on transmit");
  preload_copy_a: assert property (@(posedge clock_in) disable iff (mrst)
    irq_q && st_q == ST_TX && !con_q.rd_stretch |-> ##2 tx_q == $past(pre_q))
    else $error("preload not copied");
  msb_first_a: assert property (@(posedge clock_in) disable iff (mrst)
    st_q == ST_TX && on |-> sda_drv_q == !tx_q[7]) else $error("data line wrong");
  refused_write_a: assert property (@(posedge clock_in) disable iff (mrst)
    sfr_we_in && sfr_addr_in == OFS_DATA && !data_ok && st_q != ST_RX
    |=> wcol_q && data_q == $past(data_q)) else $error("refused write stored");
  dir_update_a: assert property (@(posedge clock_in) disable iff (mrst)
    on && !start_ev && !stop_ev && fall && st_q == ST_ADDR && cnt_q == CNT_BYTE
    && sh_q[7:1] == addr_q |=> dir_q == $past(sh_q[0])) else $error("direction stale");
  soft_reset_a: assert property (@(posedge clock_in) disable iff (rst_in)
    con_q.soft_rst |=> st_q == ST_IDLE && !wcol_q && !scl_drv_q)
    else $error("soft reset ineffective");
  read_match_c: cover property (@(posedge clock_in) disable iff (mrst)
    st_q == ST_ADDR_ACK && dir_q ##[1:1000] st_q == ST_TX);
  write_byte_c: cover property (@(posedge clock_in) disable iff (mrst)
    st_q == ST_RX_ACK && bf_q);
  collision_c: cover property (@(posedge clock_in) disable iff (mrst) $rose(wcol_q));
endmodule

// ### sim/isb_master.sv
`timescale 1ns/1ps
// far-side bus master; drive of 1 means released, wires are pulled up outside
module isb_master (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_drv_out,
  output logic      sda_drv_out,
  output logic      timeout_out
);
  initial begin
    scl_drv_out = 1'b1;
    sda_drv_out = 1'b1;
    timeout_out = 1'b0;
  end
  // release clock, then wait out any stretching; a hang raises the flag
  task automatic rise();
    int n;
    scl_drv_out = 1'b1;
    for (n = 0; n < 4000 && scl_in !== 1'b1; n++) #10;
    if (scl_in !== 1'b1) timeout_out = 1'b1;
  endtask
  // one bit, 160 ns: data moves mid-low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    #40 sda_drv_out = b;
    #40 rise();
    #70 s = sda_in;
    #10 scl_drv_out = 1'b0;
  endtask
  task automatic start();
    sda_drv_out = 1'b1;
    #40 rise();
    #40 sda_drv_out = 1'b0;
    #40 scl_drv_out = 1'b0;
  endtask
  task automatic stop();
    #40 sda_drv_out = 1'b0;
    #40 rise();
    #40 sda_drv_out = 1'b1;
    #80;
  endtask
  // byte out msb first, then sample the slave's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  // extra low time before the first bit gives the slave room to load
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    #160;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  import isb_pkg::*;
  localparam logic [7:0] DEV = 8'hA4;
  logic       clock_in = 1'b0;
  logic       rst_in, sfr_we_in, sfr_re_in, sec_we_in, sec_re_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [7:0] sec_addr_in, sec_wdata_in, sec_rdata_out;
  logic       scl_a_oe_n_out, sda_a_oe_n_out, scl_b_oe_n_out, sda_b_oe_n_out;
  logic       byte_irq_out, slew_limit_off_out, analog_filter_on_out;
  logic       m_scl, m_sda, m_to, ack;
  logic [7:0] b, d;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         irq_n = 0;
  logic [7:0] sent_q[$];
  // wired-and buses with pull-ups; set B has no master on it
  wire scl_a_in = m_scl & scl_a_oe_n_out;
  wire sda_a_in = m_sda & sda_a_oe_n_out;
  wire scl_b_in = scl_b_oe_n_out;
  wire sda_b_in = sda_b_oe_n_out;

  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) if (byte_irq_out === 1'b1) irq_n++;

  isb_top i_dut (.clock_in, .rst_in, .sfr_we_in, .sfr_re_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_rdata_out, .sec_we_in, .sec_re_in, .sec_addr_in,
    .sec_wdata_in, .sec_rdata_out, .scl_a_in, .scl_a_out(), .scl_a_oe_n_out,
    .sda_a_in, .sda_a_out(), .sda_a_oe_n_out, .scl_b_in, .scl_b_out(),
    .scl_b_oe_n_out, .sda_b_in, .sda_b_out(), .sda_b_oe_n_out, .byte_irq_out,
    .slew_limit_off_out, .analog_filter_on_out);
  isb_master i_master (.scl_in(scl_a_in), .sda_in(sda_a_in), .scl_drv_out(m_scl),
    .sda_drv_out(m_sda), .timeout_out(m_to));

  task automatic complete_run();
    if (m_to !== 1'b0) n_fail++;
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle strobes, launched a fixed 2 ns after the edge
  task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_in) #2;
    if (sec) {sec_we_in, sec_addr_in, sec_wdata_in} = {1'b1, a, v};
    else {sfr_we_in, sfr_addr_in, sfr_wdata_in} = {1'b1, a, v};
    @(posedge clock_in) #2;
    sec_we_in = 1'b0;
    sfr_we_in = 1'b0;
  endtask
  task automatic rd(input logic sec, input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_in) #2;
    if (sec) {sec_re_in, sec_addr_in} = {1'b1, a};
    else {sfr_re_in, sfr_addr_in} = {1'b1, a};
    @(posedge clock_in) #2;
    sec_re_in = 1'b0;
    sfr_re_in = 1'b0;
    v = sec ? sec_rdata_out : sfr_rdata_out;
  endtask
  task automatic rchk(input logic sec, input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] v;
    rd(sec, a, v);
    check(w, v, e);
  endtask
  // open-drain enables ordered scl_a, sda_a, scl_b, sda_b
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge clock_in);
    #2 check("oe_n", {4'h0, scl_a_oe_n_out, sda_a_oe_n_out, scl_b_oe_n_out, sda_b_oe_n_out},
      {4'h0, e});
  endtask
  task automatic put(input logic [7:0] v);
    i_master.put_byte(v, ack);
    check("ack", {7'h0, ack}, 8'h00);
  endtask
  // bounded wait for exactly one byte interrupt pulse
  task automatic wait_irq();
    int n0;
    n0 = irq_n;
    for (int i = 0; i < 100 && irq_n == n0; i++) @(posedge clock_in);
    repeat (4) @(posedge clock_in);
    check("irq", 8'(irq_n - n0), 8'h01);
  endtask

  // watchdog: a hang ends the run as a mismatch
  initial begin
    #1900000;
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h82152431));
    {sfr_we_in, sfr_re_in, sec_we_in, sec_re_in} = 4'h0;
    {sfr_addr_in, sfr_wdata_in, sec_addr_in, sec_wdata_in} = 32'h0;
    rst_in = 1'b1;
    repeat (3) @(posedge clock_in);
    #2 rst_in = 1'b0;
    // reset values of every register except the address, plus an unmapped read
    rchk(0, OFS_CON, 8'h10, "ctrl");
    rchk(0, OFS_STAT, 8'h44, "stat");
    rchk(0, OFS_DATA, DATA_RESET, "data");
    rchk(0, OFS_PRE, 8'h00, "pre");
    rchk(1, OFS_PORT, PORT_RESET, "port");
    rchk(1, OFS_FILT, 8'h02, "filt");
    rchk(1, 8'h77, 8'h00, "unmapped");
    check("afil", {7'h0, analog_filter_on_out}, 8'h01);
    // held clock only matters once the module is on
    wr(0, OFS_CON, 8'h00);
    pins(4'hF);
    wr(0, OFS_CON, 8'h03);
    pins(4'h7);
    check("slew", {7'h0, slew_limit_off_out}, 8'h01);
    wr(1, OFS_PORT, 8'h00);
    pins(4'hD);
    wr(1, OFS_PORT, PORT_RESET);
    wr(0, OFS_CON, 8'h05);
    pins(4'hF);
    check("slew", {7'h0, slew_limit_off_out}, 8'h00);
    wr(1, OFS_FILT, 8'h01);
    rchk(1, OFS_FILT, 8'h01, "filt");
    check("afil", {7'h0, analog_filter_on_out}, 8'h00);
    wr(0, OFS_ADDR, DEV);
    // master write, no stretching, random bytes through the model queue
    i_master.start();
    put(DEV);
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      sent_q.push_back(b);
      put(b);
      wait_irq();
      pins(4'hF);
      rchk(0, OFS_DATA, sent_q.pop_front(), "rx");
    end
    // write stretch: clock held after the interrupt until released
    wr(0, OFS_CON, 8'h0D);
    b = 8'($urandom);
    put(b);
    wait_irq();
    pins(4'h7);
    rchk(0, OFS_CON, 8'h09, "ctrl");
    rchk(0, OFS_DATA, b, "rx");
    wr(0, OFS_CON, 8'h0D);
    pins(4'hF);
    i_master.stop();
    // master read with read stretch
    wr(0, OFS_CON, 8'h15);
    i_master.start();
    put(DEV | 8'h01);
    wait_irq();
    pins(4'h7);
    rchk(0, OFS_CON, 8'h11, "ctrl");
    rd(0, OFS_STAT, d);
    check("dir", d & 8'h20, 8'h20);
    b = 8'($urandom);
    wr(0, OFS_DATA, b);
    wr(0, OFS_CON, 8'h15);
    wr(0, OFS_DATA, ~b);
    rchk(0, OFS_DATA, b, "data");
    rd(0, OFS_STAT, d);
    check("wcol", d & 8'h02, 8'h02);
    i_master.get_byte(1'b1, d);
    check("tx", d, b);
    wr(0, OFS_CON, 8'h15);
    i_master.stop();
    wr(0, OFS_STAT, 8'h00);
    rd(0, OFS_STAT, d);
    check("wcol", d & 8'h02, 8'h00);
    // read stretch off: preload goes out without stretching
    wr(0, OFS_CON, 8'h05);
    b = 8'($urandom);
    wr(0, OFS_PRE, b);
    i_master.start();
    put(DEV | 8'h01);
    i_master.get_byte(1'b1, d);
    check("pre tx", d, b);
    i_master.stop();
    pins(4'hF);
    // soft reset clears module state but not the secondary registers
    wr(0, OFS_CON, 8'h20);
    wr(0, OFS_CON, 8'h00);
    rchk(0, OFS_PRE, 8'h00, "pre");
    rchk(0, OFS_STAT, 8'h44, "stat");
    rchk(1, OFS_FILT, 8'h01, "filt");
    pins(4'hF);
    complete_run();
  end
endmodule
